// ---- hw/hpl_top.sv ----
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// Contract
// - preset channel 0..7, external trigger 0..3
// - type0 execute edge, type2 coincidence event
// - type1 loads on channel trigger input
// - preset value excludes both 32-bit endpoints
// - preset done after load, else error code
// - interrupts pass only while master enable set
// - external mask bit n enables port n
// - coincidence mask bit n enables port n
// - gate shows valid, or error with code
// - runtime masks win once written, before or after enable, else static
// - probe latches channel 0..3 count on trigger
// - probe armed by edge, one outstanding
// - probe busy while waiting, done with value
// - pulse meter channels 0..3, level enable
// - width unsigned microseconds up to 4000000
// - polarity 0 high width, 1 low width
// - meter busy while sampling, faults coded
module hpl_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] ext_port_in,
    input wire logic [15:0] coin_evt,
    input wire logic [31:0] cnt_value_ch0,
    input wire logic [31:0] cnt_value_ch1,
    input wire logic [31:0] cnt_value_ch2,
    input wire logic [31:0] cnt_value_ch3,
    output logic preset_load,
    output logic [2:0] preset_ch,
    output logic [31:0] preset_data,
    output logic [15:0] ext_irq_out,
    output logic [15:0] cmp_irq_out
);
    logic [15:0] ext_sync;
    logic [15:0] ext_d_r;
    logic [15:0] ext_rise;
    logic trigger_in_ch0;
    logic trigger_in_ch1;
    logic trigger_in_ch2;
    logic trigger_in_ch3;
    logic [3:0] trig_lvl;
    logic [3:0] trig_rise;
    logic bus_req;
    logic wr_en;
    logic [31:0] rd_data;

    hpl_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .async_in(ext_port_in),
        .sync_out(ext_sync)
    );

    assign trigger_in_ch0 = ext_sync[8];
    assign trigger_in_ch1 = ext_sync[9];
    assign trigger_in_ch2 = ext_sync[10];
    assign trigger_in_ch3 = ext_sync[11];
    assign trig_lvl = {trigger_in_ch3, trigger_in_ch2, trigger_in_ch1, trigger_in_ch0};
    assign ext_rise = ext_sync & ~ext_d_r;
    assign trig_rise = ext_rise[11:8];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_d_r <= 16'h0000;
        end else if (ce) begin
            ext_d_r <= ext_sync;
        end
    end

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // wishbone slave: one wait state, ack drops the cycle after it is given
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = bus_req & wb_we_i;

    logic [31:0] preset_ctrl_r;
    logic [31:0] preset_word_r;
    logic [31:0] irq_ctrl_r;
    logic [31:0] irq_rt_mask_r;
    logic [31:0] probe_ctrl_r;
    logic [31:0] pw_ctrl_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preset_ctrl_r <= hpl_pkg::RST_WORD;
            preset_word_r <= hpl_pkg::RST_WORD;
            irq_ctrl_r <= hpl_pkg::RST_WORD;
            irq_rt_mask_r <= hpl_pkg::RST_WORD;
            probe_ctrl_r <= hpl_pkg::RST_WORD;
            pw_ctrl_r <= hpl_pkg::RST_WORD;
        end else if (ce && wr_en) begin
            case (wb_adr_i)
                hpl_pkg::OFF_PRESET_CTRL: begin
                    preset_ctrl_r <= lane_merge(preset_ctrl_r, wb_dat_i, wb_sel_i);
                end
                hpl_pkg::OFF_PRESET_WORD: begin
                    preset_word_r <= lane_merge(preset_word_r, wb_dat_i, wb_sel_i);
                end
                hpl_pkg::OFF_IRQ_CTRL: begin
                    irq_ctrl_r <= lane_merge(irq_ctrl_r, wb_dat_i, wb_sel_i);
                end
                hpl_pkg::OFF_IRQ_MASK: begin
                    irq_rt_mask_r <= lane_merge(irq_rt_mask_r, wb_dat_i, wb_sel_i);
                end
                hpl_pkg::OFF_PROBE_CTRL: begin
                    probe_ctrl_r <= lane_merge(probe_ctrl_r, wb_dat_i, wb_sel_i);
                end
                hpl_pkg::OFF_PW_CTRL: begin
                    pw_ctrl_r <= lane_merge(pw_ctrl_r, wb_dat_i, wb_sel_i);
                end
                default: begin
                end
            endcase
        end
    end

    // preset loader
    hpl_pkg::hpl_state_t pr_state_r;
    logic pr_exec_d_r;
    logic pr_exec_rise;
    logic pr_done_r;
    logic pr_err_r;
    logic [15:0] pr_code_r;
    logic [2:0] pr_ch_r;
    logic [1:0] pr_type_r;
    logic [2:0] pr_ch_req;
    logic [1:0] pr_type_req;
    logic pr_fire;

    assign pr_ch_req = preset_ctrl_r[hpl_pkg::CH_HI:hpl_pkg::CH_LO];
    assign pr_type_req = preset_ctrl_r[hpl_pkg::TRIG_HI:hpl_pkg::TRIG_LO];
    // a held execute bit starts nothing; software must clear and set it again
    assign pr_exec_rise = preset_ctrl_r[hpl_pkg::BIT_EXEC] & ~pr_exec_d_r;
    assign pr_fire = (pr_type_r == hpl_pkg::TRIG_EXT) ? trig_rise[pr_ch_r[1:0]]
                                                      : coin_evt[pr_ch_r];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pr_state_r <= hpl_pkg::HPL_IDLE;
            pr_exec_d_r <= 1'b0;
            pr_done_r <= 1'b0;
            pr_err_r <= 1'b0;
            pr_code_r <= hpl_pkg::FAULT_NONE;
            pr_ch_r <= 3'h0;
            pr_type_r <= hpl_pkg::TRIG_EDGE;
            preset_load <= 1'b0;
            preset_ch <= 3'h0;
            preset_data <= hpl_pkg::RST_WORD;
        end else if (ce) begin
            pr_exec_d_r <= preset_ctrl_r[hpl_pkg::BIT_EXEC];
            preset_load <= 1'b0;
            if (pr_exec_rise) begin
                pr_done_r <= 1'b0;
                pr_err_r <= 1'b0;
                pr_code_r <= hpl_pkg::FAULT_NONE;
                pr_ch_r <= pr_ch_req;
                pr_type_r <= pr_type_req;
                pr_state_r <= hpl_pkg::HPL_IDLE;
                if (pr_type_req > hpl_pkg::TRIG_COIN) begin
                    pr_err_r <= 1'b1;
                    pr_code_r <= hpl_pkg::FAULT_TRIG;
                end else if (pr_ch_req > hpl_pkg::CH_MAX_ALL ||
                             (pr_type_req == hpl_pkg::TRIG_EXT &&
                              pr_ch_req > hpl_pkg::CH_MAX_EXT)) begin
                    pr_err_r <= 1'b1;
                    pr_code_r <= hpl_pkg::FAULT_CHAN;
                end else if (preset_word_r == hpl_pkg::PRESET_BAD_LO ||
                             preset_word_r == hpl_pkg::PRESET_BAD_HI) begin
                    pr_err_r <= 1'b1;
                    pr_code_r <= hpl_pkg::FAULT_VALUE;
                end else if (pr_type_req == hpl_pkg::TRIG_EDGE) begin
                    preset_load <= 1'b1;
                    preset_ch <= pr_ch_req;
                    preset_data <= preset_word_r;
                    pr_done_r <= 1'b1;
                end else begin
                    pr_state_r <= hpl_pkg::HPL_ARMED;
                    preset_data <= preset_word_r;
                    preset_ch <= pr_ch_req;
                end
            end else begin
                case (pr_state_r)
                    hpl_pkg::HPL_ARMED: begin
                        if (pr_fire) begin
                            preset_load <= 1'b1;
                            pr_done_r <= 1'b1;
                            pr_state_r <= hpl_pkg::HPL_IDLE;
                        end
                    end
                    default: begin
                        pr_state_r <= hpl_pkg::HPL_IDLE;
                    end
                endcase
            end
        end
    end

    // interrupt gate
    logic irq_en_d_r;
    logic [15:0] ext_mask_r;
    logic [15:0] cmp_mask_r;
    logic rt_written_r;
    logic irq_en;
    logic mask_wr;

    assign irq_en = irq_ctrl_r[hpl_pkg::BIT_EXEC];
    assign mask_wr = ce & wr_en & (wb_adr_i == hpl_pkg::OFF_IRQ_MASK);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_en_d_r <= 1'b0;
            ext_mask_r <= hpl_pkg::STATIC_EXT_MASK;
            cmp_mask_r <= hpl_pkg::STATIC_CMP_MASK;
            rt_written_r <= 1'b0;
        end else if (ce) begin
            irq_en_d_r <= irq_en;
            if (mask_wr) begin
                rt_written_r <= 1'b1;
            end
            // late runtime writes replace whatever is active
            if (irq_en_d_r && rt_written_r) begin
                ext_mask_r <= irq_rt_mask_r[15:0];
                cmp_mask_r <= irq_rt_mask_r[31:16];
            end
            if (irq_en && !irq_en_d_r) begin
                if (rt_written_r) begin
                    ext_mask_r <= irq_rt_mask_r[15:0];
                    cmp_mask_r <= irq_rt_mask_r[31:16];
                end else begin
                    ext_mask_r <= hpl_pkg::STATIC_EXT_MASK;
                    cmp_mask_r <= hpl_pkg::STATIC_CMP_MASK;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_irq_out <= 16'h0000;
            cmp_irq_out <= 16'h0000;
        end else if (ce) begin
            ext_irq_out <= ext_rise & ext_mask_r & {16{irq_en_d_r}};
            cmp_irq_out <= coin_evt & cmp_mask_r & {16{irq_en_d_r}};
        end
    end

    logic irq_valid;
    logic irq_err;
    // enabling with nothing unmasked is reported as a fault
    assign irq_err = irq_en_d_r & (ext_mask_r == 16'h0000) & (cmp_mask_r == 16'h0000);
    assign irq_valid = irq_en_d_r & ~irq_err;

    // touch probe
    hpl_pkg::hpl_state_t tp_state_r;
    logic tp_exec_d_r;
    logic tp_exec_rise;
    logic tp_done_r;
    logic tp_err_r;
    logic [15:0] tp_code_r;
    logic [1:0] tp_ch_r;
    logic [31:0] tp_value_r;
    logic [2:0] tp_ch_req;
    logic [31:0] tp_count;

    assign tp_ch_req = probe_ctrl_r[hpl_pkg::CH_HI:hpl_pkg::CH_LO];
    assign tp_exec_rise = probe_ctrl_r[hpl_pkg::BIT_EXEC] & ~tp_exec_d_r;

    always_comb begin
        case (tp_ch_r)
            2'h0: tp_count = cnt_value_ch0;
            2'h1: tp_count = cnt_value_ch1;
            2'h2: tp_count = cnt_value_ch2;
            default: tp_count = cnt_value_ch3;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tp_state_r <= hpl_pkg::HPL_IDLE;
            tp_exec_d_r <= 1'b0;
            tp_done_r <= 1'b0;
            tp_err_r <= 1'b0;
            tp_code_r <= hpl_pkg::FAULT_NONE;
            tp_ch_r <= 2'h0;
            tp_value_r <= hpl_pkg::RST_WORD;
        end else if (ce) begin
            tp_exec_d_r <= probe_ctrl_r[hpl_pkg::BIT_EXEC];
            case (tp_state_r)
                hpl_pkg::HPL_ARMED: begin
                    // execute edges while armed are ignored; a trigger edge latches the count
                    if (trig_rise[tp_ch_r]) begin
                        tp_value_r <= tp_count;
                        tp_done_r <= 1'b1;
                        tp_state_r <= hpl_pkg::HPL_IDLE;
                    end
                end
                default: begin
                    tp_state_r <= hpl_pkg::HPL_IDLE;
                    if (tp_exec_rise) begin
                        tp_done_r <= 1'b0;
                        tp_err_r <= 1'b0;
                        tp_code_r <= hpl_pkg::FAULT_NONE;
                        if (tp_ch_req > hpl_pkg::CH_MAX_EXT) begin
                            tp_err_r <= 1'b1;
                            tp_code_r <= hpl_pkg::FAULT_CHAN;
                        end else begin
                            tp_ch_r <= tp_ch_req[1:0];
                            tp_state_r <= hpl_pkg::HPL_ARMED;
                        end
                    end
                end
            endcase
        end
    end

    // pulse-width meter
    logic pw_en;
    logic pw_pol;
    logic [2:0] pw_ch;
    logic pw_bad_ch;
    logic pw_busy;
    logic pw_active;
    logic pw_active_d_r;
    logic [6:0] tick_cnt_r;
    logic tick;
    logic [31:0] pw_cnt_r;
    logic [31:0] pw_value_r;

    assign pw_en = pw_ctrl_r[hpl_pkg::BIT_EXEC];
    assign pw_pol = pw_ctrl_r[hpl_pkg::BIT_POL];
    assign pw_ch = pw_ctrl_r[hpl_pkg::CH_HI:hpl_pkg::CH_LO];
    assign pw_bad_ch = pw_en & (pw_ch > hpl_pkg::CH_MAX_EXT);
    assign pw_busy = pw_en & ~pw_bad_ch;
    assign pw_active = trig_lvl[pw_ch[1:0]] ^ pw_pol;
    assign tick = (tick_cnt_r == hpl_pkg::TICK_LAST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_cnt_r <= 7'h00;
        end else if (ce) begin
            if (!pw_busy || tick || (pw_active && !pw_active_d_r)) begin
                tick_cnt_r <= 7'h00;
            end else begin
                tick_cnt_r <= tick_cnt_r + 7'h01;
            end
        end
    end

    // level enable: measures pulse after pulse while held, stops when dropped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pw_active_d_r <= 1'b0;
            pw_cnt_r <= hpl_pkg::RST_WORD;
            pw_value_r <= hpl_pkg::RST_WORD;
        end else if (ce) begin
            pw_active_d_r <= pw_busy & pw_active;
            if (!pw_busy) begin
                pw_cnt_r <= hpl_pkg::RST_WORD;
            end else if (pw_active && !pw_active_d_r) begin
                pw_cnt_r <= hpl_pkg::RST_WORD;
            end else if (pw_active && tick && pw_cnt_r < hpl_pkg::PW_MAX_US) begin
                pw_cnt_r <= pw_cnt_r + 32'h00000001;
            end
            if (pw_busy && !pw_active && pw_active_d_r) begin
                pw_value_r <= pw_cnt_r;
            end
        end
    end

    // read mux and ack
    always_comb begin
        rd_data = 32'h00000000;
        case (wb_adr_i)
            hpl_pkg::OFF_PRESET_CTRL: rd_data = preset_ctrl_r;
            hpl_pkg::OFF_PRESET_WORD: rd_data = preset_word_r;
            hpl_pkg::OFF_PRESET_STAT: begin
                rd_data[hpl_pkg::BIT_DONE] = pr_done_r;
                rd_data[hpl_pkg::BIT_ERR] = pr_err_r;
                rd_data[hpl_pkg::BIT_BUSY] = (pr_state_r == hpl_pkg::HPL_ARMED);
                rd_data[31:hpl_pkg::CODE_LO] = pr_code_r;
            end
            hpl_pkg::OFF_IRQ_CTRL: rd_data = irq_ctrl_r;
            hpl_pkg::OFF_IRQ_MASK: rd_data = irq_rt_mask_r;
            hpl_pkg::OFF_IRQ_STAT: begin
                rd_data[hpl_pkg::BIT_DONE] = irq_valid;
                rd_data[hpl_pkg::BIT_ERR] = irq_err;
                rd_data[31:hpl_pkg::CODE_LO] = irq_err ? hpl_pkg::FAULT_MASK
                                                       : hpl_pkg::FAULT_NONE;
            end
            hpl_pkg::OFF_PROBE_CTRL: rd_data = probe_ctrl_r;
            hpl_pkg::OFF_PROBE_STAT: begin
                rd_data[hpl_pkg::BIT_DONE] = tp_done_r;
                rd_data[hpl_pkg::BIT_ERR] = tp_err_r;
                rd_data[hpl_pkg::BIT_BUSY] = (tp_state_r == hpl_pkg::HPL_ARMED);
                rd_data[31:hpl_pkg::CODE_LO] = tp_code_r;
            end
            hpl_pkg::OFF_PROBE_VALUE: rd_data = tp_value_r;
            hpl_pkg::OFF_PW_CTRL: rd_data = pw_ctrl_r;
            hpl_pkg::OFF_PW_STAT: begin
                rd_data[hpl_pkg::BIT_ERR] = pw_bad_ch;
                rd_data[hpl_pkg::BIT_BUSY] = pw_busy;
                rd_data[31:hpl_pkg::CODE_LO] = pw_bad_ch ? hpl_pkg::FAULT_CHAN
                                                         : hpl_pkg::FAULT_NONE;
            end
            hpl_pkg::OFF_PW_VALUE: rd_data = pw_value_r;
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce) begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end
endmodule // hpl_top

// ---- include/hpl_pkg.sv ----
package hpl_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [7:0] OFF_PRESET_CTRL = 8'h00;
    localparam logic [7:0] OFF_PRESET_WORD = 8'h04;
    localparam logic [7:0] OFF_PRESET_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_CTRL = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_PROBE_CTRL = 8'h18;
    localparam logic [7:0] OFF_PROBE_STAT = 8'h1c;
    localparam logic [7:0] OFF_PROBE_VALUE = 8'h20;
    localparam logic [7:0] OFF_PW_CTRL = 8'h24;
    localparam logic [7:0] OFF_PW_STAT = 8'h28;
    localparam logic [7:0] OFF_PW_VALUE = 8'h2c;

    // field positions
    localparam int BIT_EXEC = 0;
    localparam int BIT_POL = 1;
    localparam int CH_LO = 4;
    localparam int CH_HI = 6;
    localparam int TRIG_LO = 8;
    localparam int TRIG_HI = 9;
    localparam int BIT_DONE = 0;
    localparam int BIT_ERR = 1;
    localparam int BIT_BUSY = 2;
    localparam int CODE_LO = 16;

    // trigger types
    localparam logic [1:0] TRIG_EDGE = 2'h0;
    localparam logic [1:0] TRIG_EXT = 2'h1;
    localparam logic [1:0] TRIG_COIN = 2'h2;

    // counter ranges
    localparam logic [2:0] CH_MAX_ALL = 3'h7;
    localparam logic [2:0] CH_MAX_EXT = 3'h3;
    localparam logic [31:0] PRESET_BAD_LO = 32'h80000000;
    localparam logic [31:0] PRESET_BAD_HI = 32'h7fffffff;

    // fault codes
    localparam logic [15:0] FAULT_NONE = 16'h0000;
    localparam logic [15:0] FAULT_CHAN = 16'h0001;
    localparam logic [15:0] FAULT_TRIG = 16'h0002;
    localparam logic [15:0] FAULT_VALUE = 16'h0003;
    localparam logic [15:0] FAULT_MASK = 16'h0004;

    // statically configured interrupt masks
    localparam logic [15:0] STATIC_EXT_MASK = 16'h0000;
    localparam logic [15:0] STATIC_CMP_MASK = 16'h0000;

    // reset values
    localparam logic [31:0] RST_WORD = 32'h00000000;

    // timing: 1 us tick from the 10 ns system clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
    localparam logic [31:0] PW_MAX_US = 32'd4000000;

    typedef enum logic [1:0] {
        HPL_IDLE = 2'b00,
        HPL_ARMED = 2'b01
    } hpl_state_t;
endpackage

// ---- hw/hpl_sync.sv ----
`timescale 1ns/1ps
module hpl_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [15:0] async_in,
    output logic [15:0] sync_out
);
    logic [15:0] meta_r;

    // meta_r feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= 16'h0000;
            sync_out <= 16'h0000;
        end else if (ce) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule // hpl_sync

// ---- tb/hpl_top_assertions.sv ----
`timescale 1ns/1ps
module hpl_top_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [15:0] ext_port_in,
    input wire logic [15:0] coin_evt,
    input wire logic preset_load,
    input wire logic [31:0] preset_data,
    input wire logic [15:0] ext_irq_out,
    input wire logic [15:0] cmp_irq_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ack_req_a: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    ack_once_a: assert property (ce && wb_ack_o |=> !wb_ack_o) else $error("ack held");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
        else $error("read data moved");
    load_once_a: assert property (preset_load |=> !preset_load)
        else $error("load pulse too long");
    load_value_a: assert property (preset_load |-> preset_data != hpl_pkg::PRESET_BAD_LO
        && preset_data != hpl_pkg::PRESET_BAD_HI) else $error("endpoint preset loaded");
    ext_cause_a: assert property ((ext_irq_out & ~$past(ext_port_in, 3)) == 16'h0000)
        else $error("ext irq without pin");
    cmp_cause_a: assert property ((cmp_irq_out & ~$past(coin_evt)) == 16'h0000)
        else $error("cmp irq without event");
    cover property (preset_load);
    cover property (ext_irq_out != 16'h0000);
    cover property (cmp_irq_out != 16'h0000);
endmodule // hpl_top_chk
bind hpl_top hpl_top_chk u_hpl_top_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ext_port_in(ext_port_in), .coin_evt(coin_evt), .preset_load(preset_load),
    .preset_data(preset_data), .ext_irq_out(ext_irq_out), .cmp_irq_out(cmp_irq_out));

// ---- tb/hpl_core_model.sv ----
`timescale 1ns/1ps
module hpl_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic preset_load,
    input wire logic [2:0] preset_ch,
    input wire logic [31:0] preset_data,
    input wire logic [15:0] coin_req,
    output logic [15:0] coin_evt,
    output logic [31:0] cnt [4]
);
    // counts stand still between loads so latched values are exact
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            coin_evt <= 16'h0;
            cnt <= '{default: 32'h0};
        end else begin
            coin_evt <= coin_req;
            if (preset_load && preset_ch < 3'h4) begin
                cnt[preset_ch[1:0]] <= preset_data;
            end
        end
    end
endmodule // hpl_core_model

// ---- tb/test_hsc_preset_latch_pulse_width.sv ----
`timescale 1ns/1ps
module test_hsc_preset_latch_pulse_width;
    logic clk = 0, rst_n = 0, ce = 1, cyc = 0, stb = 0, we = 0, ack, pload;
    logic [7:0] adr = 8'h0;
    logic [31:0] dat = 32'h0, rdata, v, wb_rd, pdata;
    logic [31:0] pv [8];
    logic [31:0] cnt [4];
    logic [15:0] pins = 16'h0000, coin_req = 16'h0000, coin_evt, ext_irq, cmp_irq;
    logic [15:0] ext_seen, cmp_seen;
    logic [2:0] pch;
    logic [34:0] le;
    logic [31:0] rq [$];
    logic [34:0] lq [$];
    int error_cnt = 0, cmp_count = 0, seed = 16240;
    always #5 clk = ~clk;
    hpl_top u_hpl_top (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_rd),
        .wb_ack_o(ack), .ext_port_in(pins), .coin_evt(coin_evt), .cnt_value_ch0(cnt[0]),
        .cnt_value_ch1(cnt[1]), .cnt_value_ch2(cnt[2]), .cnt_value_ch3(cnt[3]),
        .preset_load(pload), .preset_ch(pch), .preset_data(pdata), .ext_irq_out(ext_irq),
        .cmp_irq_out(cmp_irq));
    hpl_core_model u_hpl_core_model (.clk(clk), .rst_n(rst_n), .preset_load(pload),
        .preset_ch(pch), .preset_data(pdata), .coin_req(coin_req), .coin_evt(coin_evt),
        .cnt(cnt));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("wb_ack", 32'h1, 32'h0);
            close_out();
        end
        rdata = wb_rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic prd(input logic [31:0] e);
        rd(hpl_pkg::OFF_PRESET_STAT, e);
    endtask
    task automatic arm(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
        wb(1'b1, a, d | 32'h1);
    endtask
    task automatic pin(input int i, input int n);
        pins[i] <= ~pins[i];
        repeat (n) @(posedge clk);
        pins[i] <= ~pins[i];
        repeat (8) @(posedge clk);
    endtask
    task automatic coin(input int i);
        coin_req[i] <= 1'b1;
        @(posedge clk);
        coin_req[i] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic pre(input logic [2:0] c, input logic [1:0] t, input logic [31:0] x);
        wb(1'b1, hpl_pkg::OFF_PRESET_WORD, x);
        arm(hpl_pkg::OFF_PRESET_CTRL, {22'h0, t, 1'b0, c, 4'h0});
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) chk("read", rq.pop_front(), wb_rd);
        ext_seen = ext_seen | ext_irq;
        cmp_seen = cmp_seen | cmp_irq;
        if (pload === 1'b1) begin
            le = (lq.size() > 0) ? lq.pop_front() : 35'h7ffffffff;
            chk("load_ch", {29'h0, le[34:32]}, {29'h0, pch});
            chk("load_data", le[31:0], pdata);
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            v = $random(seed) >>> 1;
            pv[c] = v;
            lq.push_back({3'(c), v});
            pre(3'(c), hpl_pkg::TRIG_EDGE, v);
            prd(32'h1);
        end
        pre(3'h4, hpl_pkg::TRIG_EXT, 32'h5);
        prd(32'h10002);
        pre(3'h0, 2'h3, 32'h5);
        prd(32'h20002);
        pre(3'h1, hpl_pkg::TRIG_EDGE, hpl_pkg::PRESET_BAD_LO);
        prd(32'h30002);
        pre(3'h1, hpl_pkg::TRIG_EDGE, hpl_pkg::PRESET_BAD_HI);
        prd(32'h30002);
        v = $random(seed) >>> 1;
        lq.push_back({3'h2, v});
        pre(3'h2, hpl_pkg::TRIG_EXT, v);
        prd(32'h4);
        pin(9, 5);
        pin(10, 5);
        prd(32'h1);
        lq.push_back({3'h7, 32'h123});
        pre(3'h7, hpl_pkg::TRIG_COIN, 32'h123);
        coin(6);
        coin(7);
        prd(32'h1);
        arm(hpl_pkg::OFF_PROBE_CTRL, 32'h10);
        rd(hpl_pkg::OFF_PROBE_STAT, 32'h4);
        arm(hpl_pkg::OFF_PROBE_CTRL, 32'h20);
        pin(9, 5);
        rd(hpl_pkg::OFF_PROBE_STAT, 32'h1);
        rd(hpl_pkg::OFF_PROBE_VALUE, pv[1]);
        arm(hpl_pkg::OFF_PROBE_CTRL, 32'h50);
        rd(hpl_pkg::OFF_PROBE_STAT, 32'h10002);
        wb(1'b1, hpl_pkg::OFF_IRQ_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        rd(hpl_pkg::OFF_IRQ_STAT, 32'h40002);
        wb(1'b1, hpl_pkg::OFF_IRQ_MASK, 32'h30003);
        rd(hpl_pkg::OFF_IRQ_STAT, 32'h1);
        wb(1'b1, hpl_pkg::OFF_IRQ_CTRL, 32'h0);
        wb(1'b1, hpl_pkg::OFF_IRQ_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        rd(hpl_pkg::OFF_IRQ_STAT, 32'h1);
        {ext_seen, cmp_seen} = 32'h0;
        for (int i = 0; i < 3; i++) begin
            pin(i, 5);
            coin(i);
        end
        chk("ext_irq", 32'h3, {16'h0, ext_seen});
        chk("cmp_irq", 32'h3, {16'h0, cmp_seen});
        {ext_seen, cmp_seen} = 32'h0;
        // frozen clock enable: pin and event pass unseen
        ce <= 1'b0;
        pin(1, 5);
        coin(1);
        ce <= 1'b1;
        wb(1'b1, hpl_pkg::OFF_IRQ_CTRL, 32'h0);
        pin(0, 5);
        coin(0);
        chk("irq_off", 32'h0, {ext_seen, cmp_seen});
        wb(1'b1, hpl_pkg::OFF_PW_CTRL, 32'h1);
        rd(hpl_pkg::OFF_PW_STAT, 32'h4);
        pin(8, 300);
        wb(1'b0, hpl_pkg::OFF_PW_VALUE, 32'h0);
        chk("pw_high", 32'h1, {31'h0, rdata >= 32'h2 && rdata <= 32'h3});
        pins[8] <= 1'b1;
        wb(1'b1, hpl_pkg::OFF_PW_CTRL, 32'h3);
        pin(8, 500);
        wb(1'b0, hpl_pkg::OFF_PW_VALUE, 32'h0);
        chk("pw_low", 32'h1, {31'h0, rdata >= 32'h4 && rdata <= 32'h5});
        pins[8] <= 1'b0;
        wb(1'b1, hpl_pkg::OFF_PW_CTRL, 32'h0);
        rd(hpl_pkg::OFF_PW_STAT, 32'h0);
        wb(1'b1, hpl_pkg::OFF_PW_CTRL, 32'h51);
        rd(hpl_pkg::OFF_PW_STAT, 32'h10002);
        wb(1'b1, 8'h3c, 32'hffffffff);
        rd(8'h3c, 32'h0);
        rd(hpl_pkg::OFF_PRESET_CTRL, 32'h271);
        repeat (5) @(posedge clk);
        chk("loads_left", 32'h0, lq.size());
        close_out();
    end
endmodule // test_hsc_preset_latch_pulse_width
